// [include/cipt_pkg.sv]
// Constants and types shared by the interrupt priority and trap unit
package cipt_pkg;
  // I/O offsets of the two port-mapped registers
  localparam logic [7:0] VECTOR_LOW_BASE_ADDR = 8'h33;
  localparam logic [7:0] INTERRUPT_TRAP_CONTROL_ADDR = 8'h34;
  // Reset values
  localparam logic [7:0] VECTOR_LOW_BASE_RST = 8'h00;
  localparam logic [7:0] VECTOR_HIGH_BASE_RST = 8'h00;
  localparam logic [2:0] LEVEL_ENABLE_RST = 3'h1;
  localparam logic [1:0] LEVEL0_MODE_RST = 2'h0;
  // Control register field positions
  localparam int TRAP_BIT = 7;
  localparam int FETCH_OFFSET_BIT = 6;
  localparam int LEVEL2_EN_BIT = 2;
  localparam int LEVEL1_EN_BIT = 1;
  localparam int LEVEL0_EN_BIT = 0;
  // Sources, index order is priority order, 0 highest
  localparam int NUM_SRC = 12;
  localparam int NUM_PERIPH = 7;
  localparam logic [3:0] SRC_TRAP = 4'h0;
  localparam logic [3:0] SRC_NMI = 4'h1;
  localparam logic [3:0] SRC_LEVEL0 = 4'h2;
  localparam logic [3:0] SRC_LEVEL1 = 4'h3;
  localparam logic [3:0] SRC_LEVEL2 = 4'h4;
  localparam logic [3:0] SRC_PERIPH0 = 4'h5;
  // Fixed restart addresses
  localparam logic [15:0] TRAP_RESTART = 16'h0000;
  localparam logic [15:0] NMI_RESTART = 16'h0066;
  localparam logic [15:0] LEVEL0_M1_RESTART = 16'h0038;
  // Fixed low five table bits: level-1, level-2, then the peripherals
  localparam logic [4:0] FIXED_LOW [0:8] = '{
    5'h00, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h10
  };
  typedef enum logic [1:0] {
    CIPT_TS_IDLE,
    CIPT_TS_INSERT,
    CIPT_TS_GUARD
  } cipt_trap_state_e;
endpackage

// [include/cipt_arb_if.sv]
// Request and grant bundle between the unit and its priority arbiter
`timescale 1ns/1ps
interface cipt_arb_if #(parameter int N = 12);
  logic [N-1:0] req;
  logic [3:0] grant_idx;
  logic any;
  modport arb (input req, output grant_idx, output any);
  modport ctl (output req, input grant_idx, input any);
endinterface

// [hw/cipt_sync.sv]
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module cipt_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// [hw/cipt_arbiter.sv]
// Fixed-priority arbiter, lowest request index wins
`timescale 1ns/1ps
module cipt_arbiter #(
  parameter int N = 12
) (
  // Requests in, grant out
  cipt_arb_if.arb bus
);
  always_comb begin
    bus.grant_idx = 4'h0;
    bus.any = 1'b0;
    for (int k = N - 1; k >= 0; k--) begin
      if (bus.req[k]) begin
        bus.grant_idx = 4'(k);
        bus.any = 1'b1;
      end
    end
  end
endmodule

// [hw/cipt_unit.sv]
// Interrupt priority arbitration, vector formation and undefined-opcode trap
//
// Contract
// - Twelve sources arbitrated by fixed priority, trap first, serial 1 last.
// - Vectored sources form a 16-bit table address for the restart fetch.
// - High table byte always comes from the vector-high register.
// - Vector-high reached only by load instructions; resets to zero.
// - Low byte is vector-low top three bits plus five fixed source bits; level-0 mode 2 takes the data bus.
// - Vector-low register resets to zero.
// - Trap flag set on undefined fetch; written 0 clears; 1 ignored.
// - Read-only offset bit: 0 means stacked PC-1, 1 means PC-2.
// - Bits 2..0 enable level inputs; reset enables level-0 only.
// - Master flag gates maskable sources; enable sets, disable clears both.
// - Non-maskable accept copies master into saved, then clears master.
// - Return-from-non-maskable copies saved into master.
// - Reset and maskable accepts clear both flags; return and trap don't.
// - No sampling during enable, disable or the two flag-reading loads.
// - The two flag-reading loads copy saved flag into parity flag.
// - Trap is non-maskable, raised on any undefined fetch incl. mode 0.
// - Trap sets flag, pushes PC of bad opcode, restarts at zero.
// - No bus release, refresh, DMA or wait right after trap state.
// - Non-maskable input latches falling edge; clears DMA enable, 0066H.
// - Level-0 masked by master flag or own enable; resets to mode 0.
// - Level-0 mode 1 pushes PC, clears flags, restarts at 0038H.
`timescale 1ns/1ps
module cipt_unit (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // External request pins, active low
  input wire logic nmi_n_i,
  input wire logic level0_request_n_i,
  input wire logic level1_request_n_i,
  input wire logic level2_request_n_i,
  // Internal peripheral requests, held high until serviced
  input wire logic [cipt_pkg::NUM_PERIPH-1:0] periph_req_i,
  // Internal I/O register port
  input wire logic [7:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  // Instruction strobes from the execution core
  input wire logic enable_instruction_i,
  input wire logic disable_instruction_i,
  input wire logic return_from_nonmaskable_i,
  input wire logic return_from_interrupt_i,
  input wire logic ld_a_vector_high_i,
  input wire logic ld_a_refresh_i,
  input wire logic ld_vector_high_a_i,
  input wire logic [7:0] acc_data_i,
  input wire logic set_mode_i,
  input wire logic [1:0] set_mode_val_i,
  // Sampling point and undefined fetch report
  input wire logic sample_i,
  input wire logic undef_fetch_i,
  input wire logic undef_third_byte_i,
  input wire logic [7:0] ext_vector_low_i,
  // Acceptance towards the core
  output logic accept_o,
  output logic [3:0] accept_src_o,
  output logic push_pc_o,
  output logic vectored_o,
  output logic [15:0] vector_addr_o,
  output logic fixed_restart_o,
  output logic [15:0] restart_addr_o,
  output logic mode0_fetch_o,
  output logic dma_main_enable_clr_o,
  output logic trap_insert_state_o,
  output logic no_insert_o,
  // Flag and register views
  output logic [7:0] vector_high_o,
  output logic pv_flag_o,
  output logic master_enable_flag_o,
  output logic saved_enable_flag_o
);
  import cipt_pkg::*;

  logic [3:0] pins_q;
  logic nmi_q, nmi_q_d_r, nmi_latch_r, nmi_latch_nxt;
  logic master_enable_flag_r, master_enable_flag_nxt;
  logic saved_enable_flag_r, saved_enable_flag_nxt;
  logic trap_flag_r, trap_flag_nxt;
  logic fetch_offset_flag_r, fetch_offset_flag_nxt;
  logic [2:0] level_enable_r, level_enable_nxt;
  logic [1:0] level0_mode_r, level0_mode_nxt;
  logic [7:0] vector_low_base_r, vector_low_base_nxt;
  logic [7:0] vector_high_base_r, vector_high_base_nxt;
  logic sample_ok, take, mask_ok;
  logic [7:0] low_byte;
  cipt_trap_state_e trap_state_r, trap_state_nxt;

  cipt_arb_if #(.N(NUM_SRC)) arb_bus ();

  // Pins are asynchronous to the core clock
  cipt_sync #(.W(4), .RST_VAL(4'hf)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .d_i({nmi_n_i, level0_request_n_i, level1_request_n_i,
          level2_request_n_i}),
    .q_o(pins_q)
  );
  assign nmi_q = pins_q[3];

  cipt_arbiter #(.N(NUM_SRC)) u_arb (
    .bus(arb_bus)
  );

  // Sampling is held off while flag instructions execute
  assign sample_ok = sample_i & ~(enable_instruction_i |
    disable_instruction_i | ld_a_vector_high_i | ld_a_refresh_i);
  assign mask_ok = sample_ok & master_enable_flag_r;

  always_comb begin
    arb_bus.req = '0;
    arb_bus.req[SRC_TRAP] = undef_fetch_i;
    arb_bus.req[SRC_NMI] = sample_ok & nmi_latch_r;
    arb_bus.req[SRC_LEVEL0] = mask_ok & level_enable_r[LEVEL0_EN_BIT] &
      ~pins_q[2];
    arb_bus.req[SRC_LEVEL1] = mask_ok & level_enable_r[LEVEL1_EN_BIT] &
      ~pins_q[1];
    arb_bus.req[SRC_LEVEL2] = mask_ok & level_enable_r[LEVEL2_EN_BIT] &
      ~pins_q[0];
    arb_bus.req[NUM_SRC-1:5] = mask_ok ? periph_req_i : '0;
  end
  assign take = arb_bus.any;

  // Flag and register next state
  always_comb begin
    nmi_latch_nxt = nmi_latch_r;
    if (nmi_q_d_r && !nmi_q) begin
      nmi_latch_nxt = 1'b1;
    end else if (take && arb_bus.grant_idx == SRC_NMI) begin
      nmi_latch_nxt = 1'b0;
    end
    master_enable_flag_nxt = master_enable_flag_r;
    saved_enable_flag_nxt = saved_enable_flag_r;
    if (enable_instruction_i) begin
      master_enable_flag_nxt = 1'b1;
      saved_enable_flag_nxt = 1'b1;
    end else if (disable_instruction_i) begin
      master_enable_flag_nxt = 1'b0;
      saved_enable_flag_nxt = 1'b0;
    end else if (return_from_nonmaskable_i) begin
      master_enable_flag_nxt = saved_enable_flag_r;
    end
    // Return-from-interrupt leaves both flags alone
    if (take) begin
      if (arb_bus.grant_idx == SRC_NMI) begin
        saved_enable_flag_nxt = master_enable_flag_r;
        master_enable_flag_nxt = 1'b0;
      end else if (arb_bus.grant_idx != SRC_TRAP) begin
        saved_enable_flag_nxt = 1'b0;
        master_enable_flag_nxt = 1'b0;
      end
    end
    vector_low_base_nxt = vector_low_base_r;
    level_enable_nxt = level_enable_r;
    trap_flag_nxt = trap_flag_r;
    if (io_wr_i && io_addr_i == VECTOR_LOW_BASE_ADDR) begin
      vector_low_base_nxt = {io_wdata_i[7:5], 5'h00};
    end
    if (io_wr_i && io_addr_i == INTERRUPT_TRAP_CONTROL_ADDR) begin
      level_enable_nxt = io_wdata_i[2:0];
      if (!io_wdata_i[TRAP_BIT]) begin
        trap_flag_nxt = 1'b0;
      end
    end
    fetch_offset_flag_nxt = fetch_offset_flag_r;
    // A trap in the same cycle as a clearing write wins
    if (undef_fetch_i) begin
      trap_flag_nxt = 1'b1;
      fetch_offset_flag_nxt = undef_third_byte_i;
    end
    vector_high_base_nxt = ld_vector_high_a_i ? acc_data_i :
      vector_high_base_r;
    level0_mode_nxt = set_mode_i ? set_mode_val_i : level0_mode_r;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nmi_q_d_r <= 1'b1;
      nmi_latch_r <= 1'b0;
      master_enable_flag_r <= 1'b0;
      saved_enable_flag_r <= 1'b0;
      trap_flag_r <= 1'b0;
      fetch_offset_flag_r <= 1'b0;
      level_enable_r <= LEVEL_ENABLE_RST;
      level0_mode_r <= LEVEL0_MODE_RST;
      vector_low_base_r <= VECTOR_LOW_BASE_RST;
      vector_high_base_r <= VECTOR_HIGH_BASE_RST;
    end else begin
      nmi_q_d_r <= nmi_q;
      nmi_latch_r <= nmi_latch_nxt;
      master_enable_flag_r <= master_enable_flag_nxt;
      saved_enable_flag_r <= saved_enable_flag_nxt;
      trap_flag_r <= trap_flag_nxt;
      fetch_offset_flag_r <= fetch_offset_flag_nxt;
      level_enable_r <= level_enable_nxt;
      level0_mode_r <= level0_mode_nxt;
      vector_low_base_r <= vector_low_base_nxt;
      vector_high_base_r <= vector_high_base_nxt;
    end
  end

  // Trap insert state, then one guard cycle with no inserted cycles
  always_comb begin
    case (trap_state_r)
      CIPT_TS_IDLE: trap_state_nxt = undef_fetch_i ? CIPT_TS_INSERT :
        CIPT_TS_IDLE;
      CIPT_TS_INSERT: trap_state_nxt = CIPT_TS_GUARD;
      CIPT_TS_GUARD: trap_state_nxt = undef_fetch_i ? CIPT_TS_INSERT :
        CIPT_TS_IDLE;
      default: trap_state_nxt = CIPT_TS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trap_state_r <= CIPT_TS_IDLE;
      trap_insert_state_o <= 1'b0;
      no_insert_o <= 1'b0;
    end else begin
      trap_state_r <= trap_state_nxt;
      // Decoded from the next state so the pins still come from flops
      trap_insert_state_o <= (trap_state_nxt == CIPT_TS_INSERT);
      no_insert_o <= (trap_state_nxt != CIPT_TS_IDLE);
    end
  end

  // Low table byte: data bus for level-0, base plus fixed bits from level-1 down, zero for trap and non-maskable
  always_comb begin
    if (arb_bus.grant_idx == SRC_LEVEL0) begin
      low_byte = ext_vector_low_i;
    end else if (arb_bus.grant_idx >= SRC_LEVEL1) begin
      low_byte = {vector_low_base_r[7:5],
        FIXED_LOW[arb_bus.grant_idx - SRC_LEVEL1]};
    end else begin
      low_byte = 8'h00;
    end
  end

  // Registered acceptance and views
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      accept_o <= 1'b0;
      accept_src_o <= 4'h0;
      push_pc_o <= 1'b0;
      vectored_o <= 1'b0;
      vector_addr_o <= 16'h0000;
      fixed_restart_o <= 1'b0;
      restart_addr_o <= 16'h0000;
      mode0_fetch_o <= 1'b0;
      dma_main_enable_clr_o <= 1'b0;
      io_rdata_o <= 8'h00;
      pv_flag_o <= 1'b0;
    end else begin
      accept_o <= take;
      accept_src_o <= arb_bus.grant_idx;
      push_pc_o <= take && !(arb_bus.grant_idx == SRC_LEVEL0 &&
        level0_mode_r == 2'h0);
      vectored_o <= take && arb_bus.grant_idx >= SRC_LEVEL0 &&
        !(arb_bus.grant_idx == SRC_LEVEL0 && level0_mode_r != 2'h2);
      vector_addr_o <= {vector_high_base_r, low_byte};
      fixed_restart_o <= take && (arb_bus.grant_idx <= SRC_NMI ||
        (arb_bus.grant_idx == SRC_LEVEL0 && level0_mode_r == 2'h1));
      if (arb_bus.grant_idx == SRC_NMI) begin
        restart_addr_o <= NMI_RESTART;
      end else if (arb_bus.grant_idx == SRC_LEVEL0) begin
        restart_addr_o <= LEVEL0_M1_RESTART;
      end else begin
        restart_addr_o <= TRAP_RESTART;
      end
      mode0_fetch_o <= take && arb_bus.grant_idx == SRC_LEVEL0 &&
        level0_mode_r == 2'h0;
      dma_main_enable_clr_o <= take && arb_bus.grant_idx == SRC_NMI;
      if (io_rd_i && io_addr_i == VECTOR_LOW_BASE_ADDR) begin
        io_rdata_o <= vector_low_base_r;
      end else if (io_rd_i && io_addr_i == INTERRUPT_TRAP_CONTROL_ADDR) begin
        io_rdata_o <= {trap_flag_r, fetch_offset_flag_r, 3'h0,
          level_enable_r};
      end else begin
        io_rdata_o <= 8'h00;
      end
      if (ld_a_vector_high_i || ld_a_refresh_i) begin
        pv_flag_o <= saved_enable_flag_r;
      end
    end
  end

  assign vector_high_o = vector_high_base_r;
  assign master_enable_flag_o = master_enable_flag_r;
  assign saved_enable_flag_o = saved_enable_flag_r;

  a_trap_flag_set: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) undef_fetch_i |=> trap_flag_r)
    else $error("trap flag not set after undefined fetch");
  a_trap_restart_zero: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) undef_fetch_i |=> accept_o && push_pc_o &&
    accept_src_o == 4'h0 && fixed_restart_o && restart_addr_o == 16'h0000)
    else $error("trap did not restart at zero");
  a_nmi_flag_save: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) accept_o && accept_src_o == 4'h1 |->
    !master_enable_flag_r && saved_enable_flag_r ==
    $past(master_enable_flag_r) && dma_main_enable_clr_o)
    else $error("non-maskable accept flag handling wrong");
  a_return_from_nonmaskable_restore: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) return_from_nonmaskable_i && !take &&
    !enable_instruction_i && !disable_instruction_i |=>
    master_enable_flag_r == $past(saved_enable_flag_r) &&
    $stable(saved_enable_flag_r))
    else $error("return did not restore master flag");
  a_no_sample_flag_ins: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) (enable_instruction_i || disable_instruction_i ||
    ld_a_vector_high_i || ld_a_refresh_i) && !undef_fetch_i |=> !accept_o)
    else $error("request taken during flag instruction");
  a_mask_master: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) accept_o && accept_src_o >= 4'h2 |->
    $past(master_enable_flag_r) && !master_enable_flag_r &&
    !saved_enable_flag_r)
    else $error("maskable source taken while masked");
  a_vector_high_byte: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) accept_o && vectored_o && accept_src_o >= 4'h3 |->
    vector_addr_o[15:8] == $past(vector_high_base_r) &&
    vector_addr_o[7:5] == $past(vector_low_base_r[7:5]))
    else $error("vector table address wrong");
  a_trap_no_insert: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) undef_fetch_i |=> trap_insert_state_o ##1
    (no_insert_o && !trap_insert_state_o))
    else $error("guard after trap state missing");
  a_pv_copy_flag: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) (ld_a_vector_high_i || ld_a_refresh_i) |=>
    pv_flag_o == $past(saved_enable_flag_r))
    else $error("parity flag not copied");
  a_return_from_interrupt_keeps_flags: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) return_from_interrupt_i && !take &&
    !enable_instruction_i && !disable_instruction_i &&
    !return_from_nonmaskable_i |=> $stable(master_enable_flag_r) &&
    $stable(saved_enable_flag_r))
    else $error("return from interrupt changed enable flags");
endmodule

// [bench/cipt_partner.sv]
// Behavioural model of the devices that raise requests towards the unit
`timescale 1ns/1ps
module cipt_partner (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Raise and service commands: bit 0 non-maskable, 1..3 pins, 4..10 units
  input wire logic [10:0] set_i,
  input wire logic [10:0] clr_i,
  // Request lines
  output logic nmi_n_o,
  output logic [2:0] level_n_o,
  output logic [6:0] periph_o
);
  logic [10:0] held_r;
  logic [10:0] held_nxt;

  // A request stays up until software services it
  always_comb begin
    held_nxt = (held_r | set_i) & ~clr_i;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      held_r <= 11'h000;
    end else begin
      held_r <= held_nxt;
    end
  end

  // Released pins go back to their pull-up level
  assign nmi_n_o = ~held_r[0];
  assign level_n_o = ~held_r[3:1];
  assign periph_o = held_r[10:4];
endmodule

// [bench/cpu_interrupt_priority_trap_unit_bench.sv]
// Self-checking bench for the interrupt priority and trap unit
`timescale 1ns/1ps
`define CHK(a, b) begin \
  checks_done++; \
  if ((a) !== (b)) begin \
    error_cnt++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); \
  end \
end
module cpu_interrupt_priority_trap_unit_bench;
  import cipt_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [10:0] req_set = 11'h000;
  logic [10:0] req_clr = 11'h000;
  logic nmi_n;
  logic [2:0] lvl_n;
  logic [6:0] periph;
  logic [7:0] io_addr = 8'h00;
  logic [7:0] io_wdata = 8'h00;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] acc = 8'h00;
  logic [7:0] stb = 8'h00;
  logic [1:0] mode_val = 2'h0;
  logic [1:0] how = 2'h0;
  logic third = 1'b0;
  logic [7:0] ext = 8'hc4;
  logic [7:0] rdata, vh, rv;
  logic accept, push, vec, fixed, m0, dclr, tis, noins, pv, mef, sef;
  logic [3:0] src;
  logic [15:0] vaddr, raddr;
  int error_cnt = 0;
  int checks_done = 0;

  always #2 clk_sys_i = ~clk_sys_i;

  cipt_partner u_far (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .set_i(req_set), .clr_i(req_clr), .nmi_n_o(nmi_n),
    .level_n_o(lvl_n), .periph_o(periph));

  cipt_unit u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .nmi_n_i(nmi_n), .level0_request_n_i(lvl_n[0]),
    .level1_request_n_i(lvl_n[1]), .level2_request_n_i(lvl_n[2]),
    .periph_req_i(periph), .io_addr_i(io_addr), .io_wr_i(io_wr),
    .io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(rdata),
    .enable_instruction_i(stb[0]), .disable_instruction_i(stb[1]),
    .return_from_nonmaskable_i(stb[2]), .return_from_interrupt_i(stb[3]),
    .ld_a_vector_high_i(stb[4]), .ld_a_refresh_i(stb[5]),
    .ld_vector_high_a_i(stb[6]), .acc_data_i(acc), .set_mode_i(stb[7]),
    .set_mode_val_i(mode_val), .sample_i(how[0]), .undef_fetch_i(how[1]),
    .undef_third_byte_i(third), .ext_vector_low_i(ext),
    .accept_o(accept), .accept_src_o(src), .push_pc_o(push),
    .vectored_o(vec), .vector_addr_o(vaddr), .fixed_restart_o(fixed),
    .restart_addr_o(raddr), .mode0_fetch_o(m0),
    .dma_main_enable_clr_o(dclr), .trap_insert_state_o(tis),
    .no_insert_o(noins), .vector_high_o(vh), .pv_flag_o(pv),
    .master_enable_flag_o(mef), .saved_enable_flag_o(sef));

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One core cycle of sampling, undefined fetch and instruction strobes
  task automatic go(input logic [1:0] h, input logic [7:0] s);
    @(negedge clk_sys_i);
    how = h;
    stb = s;
    @(negedge clk_sys_i);
    how = 2'h0;
    stb = 8'h00;
  endtask

  task automatic io_w(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk_sys_i);
    io_wr = 1'b0;
  endtask

  task automatic io_r(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk_sys_i);
    io_rd = 1'b0;
    d = rdata;
  endtask

  // Pins pass a two-stage synchroniser, the non-maskable one an edge latch too, so allow them settle
  task automatic req(input logic [10:0] s, input logic [10:0] c);
    @(negedge clk_sys_i);
    req_set = s;
    req_clr = c;
    @(negedge clk_sys_i);
    req_set = 11'h000;
    req_clr = 11'h000;
    repeat (5) @(negedge clk_sys_i);
  endtask

  task automatic acc_chk(input logic [3:0] s, input logic [15:0] a,
                         input logic v);
    `CHK({accept, src, vec, fixed}, {1'b1, s, v, !v})
    if (v) `CHK(vaddr, a)
    else `CHK(raddr, a)
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    error_cnt++;
    summarize();
  end

  initial begin
    repeat (12) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    io_r(8'h33, rv); `CHK(rv, 8'h00)
    io_r(8'h34, rv); `CHK(rv, 8'h01)
    io_r(8'h35, rv); `CHK(rv, 8'h00)
    `CHK({vh, mef, sef}, 10'h000)
    io_w(8'h33, 8'hff); io_r(8'h33, rv); `CHK(rv, 8'he0)
    io_w(8'h34, 8'hc7); io_r(8'h34, rv); `CHK(rv, 8'h07)
    acc = 8'h5a;
    go(2'h0, 8'h40); `CHK(vh, 8'h5a)
    // Everything below level-0 raised while still masked
    req(11'h7fc, 11'h000);
    go(2'h1, 8'h00); `CHK(accept, 1'b0)
    for (int s = 3; s < 12; s++) begin
      go(2'h0, 8'h01); `CHK({mef, sef}, 2'b11)
      go(2'h1, 8'h00);
      acc_chk(4'(s), {8'h5a, 3'h7, 5'((s - 3) * 2)}, 1'b1);
      `CHK({mef, sef}, 2'b00)
      req(11'h000, 11'(1 << (s - 1)));
    end
    req(11'h002, 11'h000);
    for (int m = 0; m < 3; m++) begin
      mode_val = 2'(m);
      go(2'h0, 8'h80);
      go(2'h0, 8'h01);
      go(2'h1, 8'h00);
      `CHK({accept, src, m0, push}, {1'b1, 4'h2, m == 0, m != 0})
      `CHK({mef, sef}, 2'b00)
      `CHK({fixed, vec}, {m == 1, m == 2})
      if (m == 1) `CHK(raddr, 16'h0038)
      if (m == 2) `CHK(vaddr, {8'h5a, ext})
    end
    io_w(8'h34, 8'h06);
    go(2'h0, 8'h01);
    go(2'h1, 8'h00); `CHK(accept, 1'b0)
    req(11'h000, 11'h002);
    io_w(8'h34, 8'h07);
    // Strobes that forbid sampling in their own cycle
    req(11'h004, 11'h000);
    go(2'h1, 8'h01); `CHK(accept, 1'b0)
    go(2'h1, 8'h10); `CHK(accept, 1'b0)
    go(2'h1, 8'h20); `CHK({accept, pv}, 2'b01)
    go(2'h1, 8'h00); acc_chk(4'h3, 16'h5ae0, 1'b1);
    req(11'h000, 11'h004);
    go(2'h0, 8'h01);
    req(11'h001, 11'h000);
    go(2'h1, 8'h00); acc_chk(4'h1, 16'h0066, 1'b0);
    `CHK({dclr, push, mef, sef}, 4'b1101)
    req(11'h000, 11'h001);
    go(2'h0, 8'h08); `CHK({mef, sef}, 2'b01)
    go(2'h0, 8'h04); `CHK({mef, sef}, 2'b11)
    third = 1'b1;
    go(2'h2, 8'h00); acc_chk(4'h0, 16'h0000, 1'b0);
    `CHK({push, tis, noins, mef, sef}, 5'h1f)
    @(negedge clk_sys_i); `CHK(noins, 1'b1)
    io_r(8'h34, rv); `CHK(rv, 8'hc7)
    io_w(8'h34, 8'hc7); io_r(8'h34, rv); `CHK(rv, 8'hc7)
    io_w(8'h34, 8'h07); io_r(8'h34, rv); `CHK(rv[7], 1'b0)
    third = 1'b0;
    go(2'h2, 8'h00);
    io_r(8'h34, rv); `CHK(rv[7:6], 2'b10)
    go(2'h0, 8'h02); `CHK({mef, sef}, 2'b00)
    summarize();
  end
endmodule
